/* File: shared/wpdc_map.svh */
// Register offsets, field positions and reset values of the block
`ifndef WPDC_MAP_SVH
`define WPDC_MAP_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define WPDC_OFF_WP_CTRL 8'h00
`define WPDC_OFF_PD_CTRL 8'h04
`define WPDC_OFF_WP_VALUE 8'h08
`define WPDC_OFF_IRQ_STAT 8'h0C
`define WPDC_OFF_IRQ_MASK 8'h10

// ----------------------------------------------------------------
// Watchpoint control fields
// ----------------------------------------------------------------
`define WPDC_WC_LINK_EN 20
`define WPDC_WC_PAIR_HI 19
`define WPDC_WC_PAIR_LO 16
`define WPDC_WC_SEC_HI 15
`define WPDC_WC_SEC_LO 14
`define WPDC_WC_BAS_HI 8
`define WPDC_WC_BAS_LO 5
`define WPDC_WC_LS_HI 4
`define WPDC_WC_LS_LO 3
`define WPDC_WC_PRIV_HI 2
`define WPDC_WC_PRIV_LO 1
`define WPDC_WC_ENABLE 0
`define WPDC_WC_RW_MASK 32'h001FC1FF
`define WPDC_WC_RESET 32'h00000000

// ----------------------------------------------------------------
// Power-down control fields and interrupt bits
// ----------------------------------------------------------------
`define WPDC_PD_HOLD 2
`define WPDC_PD_KEEP 0
`define WPDC_PD_RW_MASK 32'h00000005
`define WPDC_PD_RESET 32'h00000000
`define WPDC_IRQ_HIT 0
`define WPDC_IRQ_HELD 1
`define WPDC_IRQ_BITS 2

`endif

/* File: shared/wpdc_pkg.sv */
// Types shared by the watchpoint and power-down control block
`default_nettype none

package wpdc_pkg;

  // Non-debug reset sequencing states
  typedef enum logic [2:0] {
    WPDC_RUN = 3'b001,
    WPDC_RST = 3'b010,
    WPDC_HOLD = 3'b100
  } wpdc_rst_state_t;

endpackage : wpdc_pkg

`default_nettype wire

/* File: core/wpdc_top.sv */
// Watchpoint qualifier and power-down/reset control with Avalon-MM regs
// Contract
// - Link bit 20 set: require the chosen context-ID pair to match.
// - Bits 19:16 give the binary index of the linked pair.
// - Bits 15:14: 00 any, 01 non-secure, 10 secure, 11 reserved.
// - Bit 13 reads zero; bits 12:9 read zero and ignore writes.
// - Byte-select bits 8:5 hit only when a selected byte is touched.
// - Bits 4:3: 01 loads, 10 stores, 11 either, 00 reserved.
// - Swaps match on 01, 10, 11; load-exclusive on 01 or 11.
// - Store-exclusive hits on 10 or 11 only when monitor passes.
// - Faults on store-exclusive may occur whatever the monitor says.
// - Bits 2:1: 01 privileged, 10 unprivileged, 11 all, 00 reserved.
// - Privilege comes from the access, not the current mode.
// - Bit 0 enables the watchpoint and resets to zero.
// - Hold bit 2 keeps non-debug logic in reset after a reset.
// - Held logic stays in reset until hold bit is written zero.
// - Bit 0 drives keep-powered output directly; resets to zero.
`timescale 1ns/1ps
`include "wpdc_map.svh"
`default_nettype none

module wpdc_top #(
  parameter int PAIRS = 16,
  parameter int AW = 8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic [AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic acc_valid,
  input wire logic [31:0] acc_addr,
  input wire logic [3:0] acc_bytes,
  input wire logic acc_load,
  input wire logic acc_store,
  input wire logic acc_swap,
  input wire logic acc_excl,
  input wire logic acc_excl_pass,
  input wire logic acc_priv,
  input wire logic acc_nonsecure,
  input wire logic [PAIRS-1:0] ctx_pair_match,
  input wire logic sys_reset_req,
  output logic wp_event,
  output logic core_reset,
  output logic keep_powered_out,
  output logic irq
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Two-bit qualifier: bit 0 admits class a, bit 1 admits class b
  function automatic logic wpdc_qual(input logic [1:0] f,
                                     input logic a,
                                     input logic b);
    wpdc_qual = (f[0] & a) | (f[1] & b);
  endfunction : wpdc_qual

  // Byte-lane merge of a write into a register image
  function automatic logic [31:0] wpdc_merge(input logic [31:0] old,
                                             input logic [31:0] wd,
                                             input logic [3:0] be,
                                             input logic [31:0] rw);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw;
    wpdc_merge = (old & ~m) | (wd & m);
  endfunction : wpdc_merge

  // ----------------------------------------------------------------
  // Bus slave: one wait cycle, then the answer
  // ----------------------------------------------------------------
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [31:0] wc_ff;
  logic [31:0] pd_ff;
  logic [31:0] wv_ff;
  logic [`WPDC_IRQ_BITS-1:0] stat_ff;
  logic [`WPDC_IRQ_BITS-1:0] mask_ff;
  logic [`WPDC_IRQ_BITS-1:0] nxt_stat;
  logic [`WPDC_IRQ_BITS-1:0] ev_set;
  logic [31:0] rd_mux;

  wire logic req = avs_read | avs_write;
  wire logic take = req & ack_ff;
  wire logic wr_take = avs_write & ack_ff;
  wire logic sel_wc = avs_address == `WPDC_OFF_WP_CTRL;
  wire logic sel_pd = avs_address == `WPDC_OFF_PD_CTRL;
  wire logic sel_wv = avs_address == `WPDC_OFF_WP_VALUE;
  wire logic sel_st = avs_address == `WPDC_OFF_IRQ_STAT;
  wire logic sel_mk = avs_address == `WPDC_OFF_IRQ_MASK;

  assign avs_waitrequest = req & ~ack_ff;
  assign avs_readdata = rdata_ff;

  // Unmapped offsets read zero and drop writes
  always_comb begin
    rd_mux = 32'h00000000;
    if (sel_wc) begin
      rd_mux = wc_ff & `WPDC_WC_RW_MASK;
    end else if (sel_pd) begin
      rd_mux = pd_ff & `WPDC_PD_RW_MASK;
    end else if (sel_wv) begin
      rd_mux = {wv_ff[31:2], 2'h0};
    end else if (sel_st) begin
      rd_mux = {30'h0, stat_ff};
    end else if (sel_mk) begin
      rd_mux = {30'h0, mask_ff};
    end
  end

  // Read data captured in the wait cycle, stands at the answer edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
    end else begin
      ack_ff <= req & ~ack_ff;
      rdata_ff <= rd_mux;
    end
  end

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  // Reserved and upper bits never store, so they always read zero
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wc_ff <= `WPDC_WC_RESET;
      pd_ff <= `WPDC_PD_RESET;
      wv_ff <= 32'h00000000;
      mask_ff <= 2'h0;
    end else if (wr_take) begin
      if (sel_wc) begin
        wc_ff <= wpdc_merge(wc_ff, avs_writedata, avs_byteenable,
                            `WPDC_WC_RW_MASK);
      end
      if (sel_pd) begin
        pd_ff <= wpdc_merge(pd_ff, avs_writedata, avs_byteenable,
                            `WPDC_PD_RW_MASK);
      end
      if (sel_wv) begin
        wv_ff <= wpdc_merge(wv_ff, avs_writedata, avs_byteenable,
                            32'hFFFFFFFC);
      end
      if (sel_mk && avs_byteenable[0]) begin
        mask_ff <= avs_writedata[`WPDC_IRQ_BITS-1:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Watchpoint qualification
  // ----------------------------------------------------------------
  wire logic wc_en = wc_ff[`WPDC_WC_ENABLE];
  wire logic wc_link = wc_ff[`WPDC_WC_LINK_EN];
  wire logic [3:0] wc_pair = wc_ff[`WPDC_WC_PAIR_HI:`WPDC_WC_PAIR_LO];
  wire logic [1:0] wc_sec = wc_ff[`WPDC_WC_SEC_HI:`WPDC_WC_SEC_LO];
  wire logic [3:0] wc_bas = wc_ff[`WPDC_WC_BAS_HI:`WPDC_WC_BAS_LO];
  wire logic [1:0] wc_ls = wc_ff[`WPDC_WC_LS_HI:`WPDC_WC_LS_LO];
  wire logic [1:0] wc_priv = wc_ff[`WPDC_WC_PRIV_HI:`WPDC_WC_PRIV_LO];

  // Word compare only; lanes come from the byte-select field
  wire logic addr_ok = acc_addr[31:2] == wv_ff[31:2];
  wire logic bytes_ok = |(wc_bas & acc_bytes);
  // Swaps count as both classes; exclusive stores need a pass
  wire logic is_load = acc_load | acc_swap;
  wire logic is_store = acc_swap |
                        (acc_store & (~acc_excl | acc_excl_pass));
  wire logic type_ok = wpdc_qual(wc_ls, is_load, is_store);
  // Access privilege bit, never the core mode
  wire logic priv_ok = wpdc_qual(wc_priv, acc_priv, ~acc_priv);
  // 00 admits both states; 11 admits both states as well
  wire logic sec_ok = (wc_sec == 2'h0) |
                      wpdc_qual(wc_sec, acc_nonsecure,
                                ~acc_nonsecure);
  // Unconfigured linked pairs give whatever their match line says
  wire logic link_ok = ~wc_link |
                       ctx_pair_match[wc_pair];
  wire logic hit = acc_valid & wc_en & addr_ok & bytes_ok & type_ok &
                   priv_ok & sec_ok & link_ok;

  // Hit reported one cycle after the access; no fault path here
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wp_event <= 1'b0;
    end else begin
      wp_event <= hit;
    end
  end

  // ----------------------------------------------------------------
  // Non-debug reset sequencing
  // ----------------------------------------------------------------
  logic s1_ff;
  logic s2_ff;
  logic s3_ff;
  logic req_ff;
  wpdc_pkg::wpdc_rst_state_t st_ff;
  wpdc_pkg::wpdc_rst_state_t nxt_st;
  wire logic hold_bit = pd_ff[`WPDC_PD_HOLD];

  // Three-stage sync; level accepted only once stages two and three agree
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
      req_ff <= 1'b0;
    end else begin
      s1_ff <= sys_reset_req;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
      req_ff <= (s2_ff == s3_ff) ? s3_ff : req_ff;
    end
  end

  // A fresh reset always restarts the sequence, even from hold
  always_comb begin
    nxt_st = st_ff;
    case (st_ff)
      wpdc_pkg::WPDC_RUN: begin
        if (req_ff) begin
          nxt_st = wpdc_pkg::WPDC_RST;
        end
      end
      wpdc_pkg::WPDC_RST: begin
        if (!req_ff) begin
          nxt_st = hold_bit ? wpdc_pkg::WPDC_HOLD
                            : wpdc_pkg::WPDC_RUN;
        end
      end
      wpdc_pkg::WPDC_HOLD: begin
        if (req_ff) begin
          nxt_st = wpdc_pkg::WPDC_RST;
        end else if (!hold_bit) begin
          nxt_st = wpdc_pkg::WPDC_RUN;
        end
      end
      default: nxt_st = wpdc_pkg::WPDC_RST;
    endcase
  end

  // Power-up enters the reset state, but the hold bit resets to zero, so power-up never holds
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= wpdc_pkg::WPDC_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign core_reset = st_ff != wpdc_pkg::WPDC_RUN;
  assign keep_powered_out = pd_ff[`WPDC_PD_KEEP];

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  assign ev_set[`WPDC_IRQ_HIT] = wp_event;
  assign ev_set[`WPDC_IRQ_HELD] = (st_ff != wpdc_pkg::WPDC_HOLD) &&
                                  (nxt_st == wpdc_pkg::WPDC_HOLD);

  // Write-one-to-clear; a new event in the same cycle wins
  always_comb begin
    nxt_stat = stat_ff;
    if (wr_take && sel_st && avs_byteenable[0]) begin
      nxt_stat = stat_ff & ~avs_writedata[`WPDC_IRQ_BITS-1:0];
    end
    nxt_stat = nxt_stat | ev_set;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_ff <= 2'h0;
    end else begin
      stat_ff <= nxt_stat;
    end
  end

  assign irq = |(stat_ff & mask_ff);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);

  a_wp_disabled_quiet: assert property (
    !wc_en |=> !wp_event)
    else $error("watchpoint hit while disabled");

  a_bytes_select: assert property (
    wp_event |-> $past(|(acc_bytes & wc_bas)))
    else $error("hit without a selected byte");

  a_link_pair: assert property (
    wp_event && $past(wc_link) |-> $past(ctx_pair_match[wc_pair]))
    else $error("linked hit without pair match");

  a_sec_state: assert property (
    wp_event |-> $past(wc_sec != 2'h3) &&
    !($past(wc_sec == 2'h1) && $past(!acc_nonsecure)) &&
    !($past(wc_sec == 2'h2) && $past(acc_nonsecure)))
    else $error("hit in wrong security state");

  a_excl_store_fail: assert property (
    acc_valid && acc_store && acc_excl && !acc_excl_pass && !acc_swap &&
    !acc_load |=> !wp_event)
    else $error("failed exclusive store hit");

  a_priv_level: assert property (
    wp_event |-> $past(wc_priv[acc_priv ? 0 : 1]))
    else $error("hit with wrong privilege");

  a_keep_powered_follow: assert property (
    wr_take && sel_pd && avs_byteenable[0] |=>
    keep_powered_out == $past(avs_writedata[`WPDC_PD_KEEP]))
    else $error("keep-powered not following write");

  a_hold_stays: assert property (
    st_ff == wpdc_pkg::WPDC_HOLD && hold_bit && !req_ff |=> core_reset)
    else $error("held reset released early");

  a_reserved_raz: assert property (
    wc_ff[13:9] == 5'h00 && pd_ff[31:3] == 29'h0 && !pd_ff[1])
    else $error("reserved bits stored");

  // A reported hit must land in the sticky status bit
  a_hit_sticky: assert property (
    wp_event |=> stat_ff[`WPDC_IRQ_HIT])
    else $error("hit not latched in status");

  // A one written to the hit bit clears it when no new hit arrives
  a_stat_clear: assert property (
    wr_take && sel_st && avs_byteenable[0] &&
    avs_writedata[`WPDC_IRQ_HIT] && !wp_event |=> !stat_ff[`WPDC_IRQ_HIT])
    else $error("status bit not cleared by write");

  c_hit_seen: cover property (wp_event);
  c_linked_hit: cover property (wp_event && wc_link);
  c_hold_release: cover property (
    st_ff == wpdc_pkg::WPDC_HOLD ##1 st_ff == wpdc_pkg::WPDC_RUN);
  c_irq_raised: cover property (irq);

endmodule : wpdc_top

`default_nettype wire

/* File: verification/wpdc_pwr_model.sv */
// Power controller model facing the keep-powered request
`timescale 1ns/1ps
`default_nettype none

module wpdc_pwr_model (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic keep_powered_out,
  input wire logic pd_req,
  output logic powered_ff
);
  // Power drops only when no emulate request stands against it
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powered_ff <= 1'b1;
    end else begin
      powered_ff <= !pd_req || keep_powered_out;
    end
  end
endmodule : wpdc_pwr_model

`default_nettype wire

/* File: verification/tb.sv */
// Self-checking bench for the watchpoint and power-down control block
`timescale 1ns/1ps
`default_nettype none

module tb;
  logic clock, rst_n, avs_read, avs_write, acc_valid, sys_reset_req;
  logic [7:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, acc_addr, cur_addr;
  logic avs_waitrequest, acc_load, acc_store, acc_swap, acc_excl;
  logic acc_excl_pass, acc_priv, acc_nonsecure, pd_req, powered_ff;
  logic [3:0] acc_bytes;
  logic [15:0] ctx_pair_match;
  logic wp_event, core_reset, keep_powered_out, irq;
  int n_fail, cmp_count, cyc;

  wpdc_top u_dut (.clock(clock), .rst_n(rst_n), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .acc_valid(acc_valid), .acc_addr(acc_addr), .acc_bytes(acc_bytes),
    .acc_load(acc_load), .acc_store(acc_store), .acc_swap(acc_swap),
    .acc_excl(acc_excl), .acc_excl_pass(acc_excl_pass),
    .acc_priv(acc_priv), .acc_nonsecure(acc_nonsecure),
    .ctx_pair_match(ctx_pair_match), .sys_reset_req(sys_reset_req),
    .wp_event(wp_event), .core_reset(core_reset),
    .keep_powered_out(keep_powered_out), .irq(irq));

  wpdc_pwr_model u_pwr (.clock(clock), .rst_n(rst_n),
    .keep_powered_out(keep_powered_out), .pd_req(pd_req),
    .powered_ff(powered_ff));

  // ------------------------------------------------------------
  // Shared helpers
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("Checks %0d, mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : tally_and_finish

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q);
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do @(posedge clock); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    #1;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus(1'b0, a, 32'h00000000, q);
  endtask : rd

  // Watchpoint control image from its fields
  function automatic logic [31:0] wc(input logic lk, input logic [3:0] pr,
      input logic [1:0] sc, input logic [3:0] bs, input logic [1:0] ls,
      input logic [1:0] pv, input logic en);
    return {11'h000, lk, pr, sc, 5'h00, bs, ls, pv, en};
  endfunction : wc

  // One access; cls is load, store, swap, exclusive
  task automatic access(input logic [3:0] by, input logic [3:0] cls,
      input logic ps, pv, ns, output logic hit);
    @(posedge clock);
    acc_valid <= 1'b1;
    acc_addr <= cur_addr;
    acc_bytes <= by;
    {acc_load, acc_store, acc_swap, acc_excl} <= cls;
    acc_excl_pass <= ps;
    acc_priv <= pv;
    acc_nonsecure <= ns;
    @(posedge clock);
    acc_valid <= 1'b0;
    #1 hit = wp_event;
  endtask : access

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    rd(8'h00, q); check("wc reset", q, 32'h00000000);
    rd(8'h04, q); check("pd reset", q, 32'h00000000);
    wr(8'h00, 32'hFFFFFFFF);
    rd(8'h00, q); check("wc mask", q, 32'h001FC1FF);
    wr(8'h04, 32'hFFFFFFFA);
    rd(8'h04, q); check("pd raz", q, 32'h00000000);
    wr(8'h04, 32'h00000001);
    check("keep out", keep_powered_out, 32'h00000001);
    @(posedge clock);
    pd_req <= 1'b1;
    repeat (2) @(posedge clock);
    #1 check("powered", powered_ff, 32'h00000001);
    wr(8'h04, 32'h00000000);
    check("keep low", keep_powered_out, 32'h00000000);
    // Without the request standing, power may really go
    repeat (2) @(posedge clock);
    #1 check("dropped", powered_ff, 32'h00000000);
    @(posedge clock);
    pd_req <= 1'b0;
    rd(8'h40, q); check("unmapped", q, 32'h00000000);
    $display("test regs done");
  endtask : t_regs

  task automatic t_fields();
    logic h;
    logic [1:0] l;
    logic [1:0] s;
    // Reserved encodings are never programmed into any field
    for (int i = 1; i < 4; i++) begin
      l = i[1:0];
      s = l - 2'b01;
      wr(8'h00, wc(1'b0, 4'h0, 2'b00, 4'hF, l, 2'b11, 1'b1));
      access(4'hF, 4'b1000, 0, 1, 0, h); check("ld", h, l[0]);
      access(4'hF, 4'b0100, 0, 1, 0, h); check("st", h, l[1]);
      access(4'hF, 4'b0010, 0, 1, 0, h); check("swp", h, l != 0);
      access(4'hF, 4'b1001, 0, 1, 0, h); check("ldx", h, l[0]);
      access(4'hF, 4'b0101, 0, 1, 0, h); check("stx0", h, 0);
      access(4'hF, 4'b0101, 1, 1, 0, h); check("stx1", h, l[1]);
      wr(8'h00, wc(1'b0, 4'h0, 2'b00, 4'hF, 2'b11, l, 1'b1));
      access(4'hF, 4'b1000, 0, 1, 0, h); check("prv", h, l[0]);
      access(4'hF, 4'b1000, 0, 0, 0, h); check("usr", h, l[1]);
      wr(8'h00, wc(1'b0, 4'h0, s, 4'hF, 2'b11, 2'b11, 1'b1));
      access(4'hF, 4'b1000, 0, 1, 1, h);
      check("ns", h, s == 0 || s == 1);
      access(4'hF, 4'b1000, 0, 1, 0, h);
      check("sec", h, s == 0 || s == 2);
    end
    $display("test fields done");
  endtask : t_fields

  task automatic t_bytes_link();
    logic h;
    wr(8'h00, wc(1'b0, 4'h0, 2'b00, 4'b0100, 2'b11, 2'b11, 1'b1));
    access(4'b0010, 4'b1000, 0, 1, 0, h); check("bas0", h, 0);
    access(4'b0100, 4'b1000, 0, 1, 0, h); check("bas1", h, 1);
    cur_addr <= 32'h00001004;
    access(4'b0100, 4'b1000, 0, 1, 0, h); check("word", h, 0);
    cur_addr <= 32'h00001000;
    wr(8'h00, wc(1'b0, 4'h0, 2'b00, 4'hF, 2'b11, 2'b11, 1'b0));
    access(4'hF, 4'b1000, 0, 1, 0, h); check("off", h, 0);
    // Pair 5 stands for one set up for context matching
    wr(8'h00, wc(1'b1, 4'h5, 2'b00, 4'hF, 2'b11, 2'b11, 1'b1));
    @(posedge clock);
    ctx_pair_match <= 16'h0010;
    access(4'hF, 4'b1000, 0, 1, 0, h); check("lnk0", h, 0);
    @(posedge clock);
    ctx_pair_match <= 16'h0020;
    access(4'hF, 4'b1000, 0, 1, 0, h); check("lnk1", h, 1);
    @(posedge clock);
    ctx_pair_match <= 16'h0000;
    wr(8'h00, wc(1'b0, 4'h5, 2'b00, 4'hF, 2'b11, 2'b11, 1'b1));
    access(4'hF, 4'b1000, 0, 1, 0, h); check("nolnk", h, 1);
    $display("test bytes and link done");
  endtask : t_bytes_link

  task automatic t_irq_hold();
    logic h;
    logic [31:0] q;
    wr(8'h0C, 32'h00000003);
    wr(8'h10, 32'h00000003);
    check("irq idle", irq, 0);
    access(4'hF, 4'b1000, 0, 1, 0, h);
    // Status latches one edge after the hit pulse
    @(posedge clock);
    #1 check("irq set", irq, 1);
    rd(8'h0C, q); check("stat", q, 32'h00000001);
    wr(8'h0C, 32'h00000001); check("irq clr", irq, 0);
    wr(8'h10, 32'h00000000);
    access(4'hF, 4'b1000, 0, 1, 0, h);
    @(posedge clock);
    #1 check("irq mask", irq, 0);
    wr(8'h0C, 32'h00000001);
    wr(8'h04, 32'h00000004);
    @(posedge clock);
    sys_reset_req <= 1'b1;
    repeat (8) @(posedge clock);
    sys_reset_req <= 1'b0;
    repeat (12) @(posedge clock);
    #1 check("held", core_reset, 1);
    rd(8'h0C, q); check("stat held", q, 32'h00000002);
    wr(8'h04, 32'h00000000);
    repeat (2) @(posedge clock);
    #1 check("freed", core_reset, 0);
    @(posedge clock);
    sys_reset_req <= 1'b1;
    repeat (8) @(posedge clock);
    #1 check("in rst", core_reset, 1);
    @(posedge clock);
    sys_reset_req <= 1'b0;
    repeat (12) @(posedge clock);
    #1 check("no hold", core_reset, 0);
    $display("test irq and hold done");
  endtask : t_irq_hold

  // ------------------------------------------------------------
  // Clock, reset, sequence and timeout
  // ------------------------------------------------------------
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  // Ceiling far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      tally_and_finish();
    end
  end

  initial begin
    {rst_n, avs_read, avs_write, acc_valid, sys_reset_req} = 5'h00;
    {acc_load, acc_store, acc_swap, acc_excl, acc_excl_pass} = 5'h00;
    {acc_priv, acc_nonsecure, pd_req} = 3'h0;
    {avs_address, avs_writedata, acc_addr, acc_bytes} = 76'h0;
    ctx_pair_match = 16'h0000;
    cur_addr = 32'h00001000;
    n_fail = 0;
    cmp_count = 0;
    cyc = 0;
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    check("keep rst", keep_powered_out, 0);
    wr(8'h08, 32'h00001000);
    t_regs();
    t_fields();
    t_bytes_link();
    t_irq_hold();
    tally_and_finish();
  end
endmodule : tb

`default_nettype wire
